/* File: rtl/sel_consts.vh */
`ifndef SEL_CONSTS_VH
`define SEL_CONSTS_VH
// ==========================================================
// Measurement event word layout
`define SEL_MEAS_W          15
`define SEL_MEAS_OUT_ONE    0
`define SEL_MEAS_OUT_TWO    1
`define SEL_MEAS_UNUSED     2
`define SEL_MEAS_LOCK_LOST  3
`define SEL_MEAS_RANGE      4
`define SEL_MEAS_SYNC_FREQ  5
`define SEL_MEAS_SYNC_OVL   6
`define SEL_MEAS_STORAGE_TRIGGERED       7
`define SEL_MEAS_DATA_LO    8
`define SEL_MEAS_DATA_HI    11
`define SEL_MEAS_CAPTURE    12
`define SEL_MEAS_SWEEP_ST   13
`define SEL_MEAS_SWEEP_FIN  14
`define SEL_MEAS_RESET      15'h0000
`define SEL_MEAS_USED       15'h7ffb
// ==========================================================
// Interface error byte layout
`define SEL_ERR_W           8
`define SEL_ERR_CLK         0
`define SEL_ERR_BACKUP      1
`define SEL_ERR_NET         4
`define SEL_ERR_PBUS        5
`define SEL_ERR_DEV_PORT    6
`define SEL_ERR_HOST_PORT   7
`define SEL_ERR_RESET       8'h00
`define SEL_ERR_USED        8'hf3
// ==========================================================
// Serial poll summary bits
`define SEL_SUM_ERR         2
`define SEL_SUM_MEAS        3
`define SEL_POLL_W          8
`define SEL_POLL_RESET      8'h00
`endif

/* File: rtl/sel_status_event_latches.v */
`timescale 1ns/1ps
`default_nettype none
`include "sel_consts.vh"

// Overview of operation
// - Output channel one and two scale overloads set event bits 0 and 1.
// - Loss of reference or chopper lock sets event bit 3.
// - A signal input range overload sets event bit 4.
// - Sync filter frequency out of range sets bit 5 and sync filter overload sets bit 6.
// - The data storage trigger sets event bit 7.
// - Data channel one to four overloads set event bits 8 to 11.
// - Completion of a screen capture to removable memory sets event bit 12.
// - Event bits stay set until the event word is read or status is cleared.
// - Reference clock input fault sets error bit 0 and battery backup failure sets bit 1.
// - Network interface error sets error bit 4 and parallel bus fast transfer abort bit 5.
// - Device port fault sets error bit 6, host port fault bit 7, bits 2 and 3 read zero.
// - Error bits stay set until the error byte is read or status is cleared.
// - A status bit reads one when its event happened or its condition is present.
// - Summary bits 2 and 3 are set when any status bit and its enable bit are both set.
// - A summary bit clears only once no enabled bit of its source remains set.
module sel_status_event_latches (
  // Clock and reset
  input  wire        I_CLOCK,
  input  wire        I_SYS_RST,

  // Measurement conditions
  input  wire        i_out_one_overload,
  input  wire        i_out_two_overload,
  input  wire        i_reference_lock_lost,
  input  wire        i_range_overload,
  input  wire        i_sync_freq_out_of_range,
  input  wire        i_sync_filter_overload,
  input  wire        i_storage_triggered,
  input  wire [3:0]  i_data_overload,
  input  wire        i_screen_capture_done,
  input  wire        i_sweep_started,
  input  wire        i_sweep_finished,

  // Interface faults
  input  wire        i_ref_clock_fault,
  input  wire        i_backup_failed,
  input  wire        i_network_fault,
  input  wire        i_parallel_bus_abort,
  input  wire        i_device_port_fault,
  input  wire        i_host_port_fault,

  // Host side strobes and enable masks
  input  wire        i_meas_read,
  input  wire        i_err_read,
  input  wire        i_clear_status,
  input  wire [14:0] i_meas_enable,
  input  wire [7:0]  i_err_enable,

  // Status views
  output wire [14:0] O_MEAS_STATUS,
  output wire [7:0]  O_ERR_STATUS,
  output wire [7:0]  O_POLL_SUMMARY
);

  // ==========================================================
  // Layout constants
  localparam MEAS_W = `SEL_MEAS_W;
  localparam ERR_W  = `SEL_ERR_W;
  localparam POLL_W = `SEL_POLL_W;

  localparam [MEAS_W-1:0] MEAS_USED  = `SEL_MEAS_USED;
  localparam [MEAS_W-1:0] MEAS_RESET = `SEL_MEAS_RESET;
  localparam [ERR_W-1:0]  ERR_USED   = `SEL_ERR_USED;
  localparam [ERR_W-1:0]  ERR_RESET  = `SEL_ERR_RESET;
  localparam [POLL_W-1:0] POLL_RESET = `SEL_POLL_RESET;

  // ==========================================================
  // Event gathering, measurement word
  // Conditions are levels, so a lasting one sets its bit again after a read
  reg  [MEAS_W-1:0] meas_evt;

  always @* begin
    meas_evt                        = MEAS_RESET;
    meas_evt[`SEL_MEAS_OUT_ONE]     = i_out_one_overload;
    meas_evt[`SEL_MEAS_OUT_TWO]     = i_out_two_overload;
    meas_evt[`SEL_MEAS_LOCK_LOST]   = i_reference_lock_lost;
    meas_evt[`SEL_MEAS_RANGE]       = i_range_overload;
    meas_evt[`SEL_MEAS_SYNC_FREQ]   = i_sync_freq_out_of_range;
    meas_evt[`SEL_MEAS_SYNC_OVL]    = i_sync_filter_overload;
    meas_evt[`SEL_MEAS_STORAGE_TRIGGERED]        = i_storage_triggered;
    meas_evt[`SEL_MEAS_DATA_HI:`SEL_MEAS_DATA_LO] = i_data_overload;
    meas_evt[`SEL_MEAS_CAPTURE]     = i_screen_capture_done;
    meas_evt[`SEL_MEAS_SWEEP_ST]    = i_sweep_started;
    meas_evt[`SEL_MEAS_SWEEP_FIN]   = i_sweep_finished;
    // Unused bit never latches
    meas_evt[`SEL_MEAS_UNUSED]      = 1'b0;
  end

  // ==========================================================
  // Event gathering, error byte
  reg  [ERR_W-1:0]  err_evt;

  always @* begin
    err_evt                         = ERR_RESET;
    err_evt[`SEL_ERR_CLK]           = i_ref_clock_fault;
    err_evt[`SEL_ERR_BACKUP]        = i_backup_failed;
    err_evt[`SEL_ERR_NET]           = i_network_fault;
    err_evt[`SEL_ERR_PBUS]          = i_parallel_bus_abort;
    err_evt[`SEL_ERR_DEV_PORT]      = i_device_port_fault;
    err_evt[`SEL_ERR_HOST_PORT]     = i_host_port_fault;
  end

  // ==========================================================
  // Clear requests
  // A read strobe clears only its own register, the clear command clears both
  wire              meas_clr;
  wire              err_clr;

  assign meas_clr = i_meas_read | i_clear_status;
  assign err_clr  = i_err_read | i_clear_status;

  // ==========================================================
  // Sticky latches, measurement word
  // Set wins over clear, so an event in the clearing cycle is never lost
  wire [MEAS_W-1:0] meas_sts;
  genvar            mb;

  generate
    for (mb = 0; mb < MEAS_W; mb = mb + 1) begin : g_meas_bit
      wire lat_set;
      wire lat_clr;
      reg  lat_nxt;
      reg  lat_r;

      // Unused places are masked here so they can never latch
      assign lat_set = meas_evt[mb] & MEAS_USED[mb];
      assign lat_clr = meas_clr;

      always @* begin
        if (lat_set) begin
          lat_nxt = 1'b1;
        end else if (lat_clr) begin
          lat_nxt = 1'b0;
        end else begin
          lat_nxt = lat_r;
        end
      end

      always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          lat_r <= MEAS_RESET[mb];
        end else begin
          lat_r <= lat_nxt;
        end
      end

      assign meas_sts[mb] = lat_r;
    end
  endgenerate

  // ==========================================================
  // Sticky latches, error byte
  // Same scheme as the measurement word, with its own clear strobe
  wire [ERR_W-1:0]  err_sts;
  genvar            eb;

  generate
    for (eb = 0; eb < ERR_W; eb = eb + 1) begin : g_err_bit
      wire lat_set;
      wire lat_clr;
      reg  lat_nxt;
      reg  lat_r;

      // Unused places are masked here so they can never latch
      assign lat_set = err_evt[eb] & ERR_USED[eb];
      assign lat_clr = err_clr;

      always @* begin
        if (lat_set) begin
          lat_nxt = 1'b1;
        end else if (lat_clr) begin
          lat_nxt = 1'b0;
        end else begin
          lat_nxt = lat_r;
        end
      end

      always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          lat_r <= ERR_RESET[eb];
        end else begin
          lat_r <= lat_nxt;
        end
      end

      assign err_sts[eb] = lat_r;
    end
  endgenerate

  // ==========================================================
  // Serial poll summary
  // Combinational, so dropping the enable of the last enabled set bit clears the summary at once
  wire [MEAS_W-1:0] meas_hit;
  wire [ERR_W-1:0]  err_hit;
  wire              sum_meas;
  wire              sum_err;
  reg  [POLL_W-1:0] poll_sum;

  assign meas_hit = meas_sts & i_meas_enable;
  assign err_hit  = err_sts & i_err_enable;
  assign sum_meas = |meas_hit;
  assign sum_err  = |err_hit;

  // Other poll bits belong to status sources outside this block and read zero
  always @* begin
    poll_sum                = POLL_RESET;
    poll_sum[`SEL_SUM_ERR]  = sum_err;
    poll_sum[`SEL_SUM_MEAS] = sum_meas;
  end

  // ==========================================================
  // Outputs
  // Status views come straight from the latch flops
  assign O_MEAS_STATUS  = meas_sts;
  assign O_ERR_STATUS   = err_sts;
  assign O_POLL_SUMMARY = poll_sum;

endmodule
`default_nettype wire

/* File: sim/sel_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks
module sel_status_props (
  input wire logic        I_CLOCK,
  input wire logic        I_SYS_RST,
  input wire logic        i_range_overload,
  input wire logic        i_host_port_fault,
  input wire logic        i_ref_clock_fault,
  input wire logic        i_meas_read,
  input wire logic        i_err_read,
  input wire logic        i_clear_status,
  input wire logic [14:0] i_meas_enable,
  input wire logic [14:0] O_MEAS_STATUS,
  input wire logic [7:0]  i_err_enable,
  input wire logic [7:0]  O_ERR_STATUS,
  input wire logic [7:0]  O_POLL_SUMMARY
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  property p_rng; i_range_overload |=> O_MEAS_STATUS[4]; endproperty
  a_rng: assert property (p_rng) else $error("range bit");
  property p_hst; i_host_port_fault |=> O_ERR_STATUS[7]; endproperty
  a_hst: assert property (p_hst) else $error("host bit");
  property p_nil; !O_MEAS_STATUS[2] && O_ERR_STATUS[3:2] == 2'h0; endproperty
  a_nil: assert property (p_nil) else $error("unused bit");
  property p_mh;
    !i_meas_read && !i_clear_status |=> ($past(O_MEAS_STATUS) & ~O_MEAS_STATUS) == 0;
  endproperty
  a_mh: assert property (p_mh) else $error("event lost");
  property p_eh;
    !i_err_read && !i_clear_status |=> ($past(O_ERR_STATUS) & ~O_ERR_STATUS) == 0;
  endproperty
  a_eh: assert property (p_eh) else $error("error lost");
  property p_clr; i_clear_status |=> O_MEAS_STATUS[4] == $past(i_range_overload); endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_er; i_err_read |=> O_ERR_STATUS[0] == $past(i_ref_clock_fault); endproperty
  a_er: assert property (p_er) else $error("error read");
  property p_sum;
    O_POLL_SUMMARY == {4'h0, |(O_MEAS_STATUS & i_meas_enable),
                       |(O_ERR_STATUS & i_err_enable), 2'h0};
  endproperty
  a_sum: assert property (p_sum) else $error("summary");
endmodule
bind sel_status_event_latches sel_status_props i_props (.*);
`default_nettype wire

/* File: sim/tb_sel_status_event_latches.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sel_status_event_latches;
  // ==========================================
  // Event vector mirrors the status layout; unused places must never latch
  localparam logic [22:0] VM = 23'h79_fffb;
  logic        clk = 1'b0, rst = 1'b1;
  logic [22:0] ev = 23'h0, acc = 23'h0, nev;
  logic [2:0]  rd = 3'h0;
  logic [14:0] me = 15'h0;
  logic [7:0]  ee = 8'h0;
  wire  [14:0] ms;
  wire  [7:0]  es, ps;
  logic [30:0] q[$], x;
  int          failures = 0, n_compared = 0, t, n;
  initial forever #50 clk = ~clk;
  sel_status_event_latches i_sel_status_event_latches (.I_CLOCK(clk), .I_SYS_RST(rst),
    .i_out_one_overload(ev[0]), .i_out_two_overload(ev[1]), .i_reference_lock_lost(ev[3]),
    .i_range_overload(ev[4]), .i_sync_freq_out_of_range(ev[5]), .i_sync_filter_overload(ev[6]),
    .i_storage_triggered(ev[7]), .i_data_overload(ev[11:8]), .i_screen_capture_done(ev[12]),
    .i_sweep_started(ev[13]), .i_sweep_finished(ev[14]), .i_ref_clock_fault(ev[15]),
    .i_backup_failed(ev[16]), .i_network_fault(ev[19]), .i_parallel_bus_abort(ev[20]),
    .i_device_port_fault(ev[21]), .i_host_port_fault(ev[22]), .i_meas_read(rd[0]),
    .i_err_read(rd[1]), .i_clear_status(rd[2]), .i_meas_enable(me), .i_err_enable(ee),
    .O_MEAS_STATUS(ms), .O_ERR_STATUS(es), .O_POLL_SUMMARY(ps));
  task automatic step(input logic [22:0] e, input logic [2:0] r);
    @(negedge clk);
    ev = e;
    rd = r;
    me = 15'($urandom);
    ee = 8'($urandom);
    acc = (acc & ~{{8{r[1] | r[2]}}, {15{r[0] | r[2]}}}) | (e & VM);
    q.push_back({4'h0, |(acc[14:0] & me), |(acc[22:15] & ee), 2'h0, acc});
  endtask
  always @(posedge clk) if (q.size() > 0) begin
    #1 x = q.pop_front();
    n_compared++;
    if ({ps, es, ms} !== x) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, {ps, es, ms}, x);
    end
  end
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h441f_2dbc));
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // Test 1 walks one event at a time, test 0 is sparse, test 2 dense
    for (t = 0; t < 3; t++) begin
      for (n = 0; n < 120; n++) begin
        nev = t == 1 ? 23'h1 << (n % 23)
                     : 23'($urandom & $urandom & (t == 2 ? 32'hffff_ffff : $urandom));
        step(nev, 3'($urandom & $urandom));
      end
      $display("test %0d done", t);
    end
    // Test 3 holds reset over a burst of events, which must not latch
    @(negedge clk);
    rst = 1'b1;
    ev  = 23'h7f_ffff;
    acc = 23'h0;
    q.push_back({8'h00, acc});
    @(negedge clk);
    rst = 1'b0;
    ev  = 23'h0;
    rd  = 3'h0;
    q.push_back({8'h00, acc});
    $display("test 3 done");
    step(23'h0, 3'h0);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
